/* hw/nsr_map.svh */
// Purpose: offsets, sequence addresses and timing counts for nsr host
// Assumes: 250 MHz clock
// Notes: counts derive from times in ns
`ifndef NSR_MAP_SVH
`define NSR_MAP_SVH

`define NSR_CLK_NS 4
`define NSR_ACCESS_NS 45
`define NSR_ACCESS_CYC ((`NSR_ACCESS_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_SB_PULSE_NS 100
`define NSR_SB_PULSE_CYC ((`NSR_SB_PULSE_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_SB_LOW_NS 20000
`define NSR_SB_LOW_CYC ((`NSR_SB_LOW_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)
`define NSR_NV_NS 10000000
`define NSR_NV_CYC ((`NSR_NV_NS + `NSR_CLK_NS - 1) / `NSR_CLK_NS)

`define NSR_SEQ_A0 13'h0000
`define NSR_SEQ_A1 13'h1555
`define NSR_SEQ_A2 13'h0AAA
`define NSR_SEQ_A3 13'h1FFF
`define NSR_SEQ_A4 13'h10F0
`define NSR_SEQ_STORE 13'h0F0F
`define NSR_SEQ_RECALL 13'h0F0E
`define NSR_SEQ_LAST 3'h5

`endif

/* hw/nsr_pkg.sv */
// Purpose: types for nsr host
// Assumes: 13-bit address, 8-bit data
// Notes: constants live in nsr_map.svh
package nsr_pkg;
    typedef enum logic [2:0] {
        NSR_OP_READ = 3'h0,
        NSR_OP_WRITE = 3'h1,
        NSR_OP_SW_STORE = 3'h2,
        NSR_OP_SW_RECALL = 3'h3,
        NSR_OP_HW_STORE = 3'h4
    } nsr_op_type;

    typedef struct packed {
        nsr_op_type op;
        logic [12:0] addr;
        logic [7:0] wdata;
    } nsr_cmd_type;

    typedef struct packed {
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic [12:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
        logic sb_o;
        logic sb_oe;
    } nsr_pins_type;
endpackage : nsr_pkg

/* hw/nsr_sync.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: one clock
// Notes: first flop read only by second
`timescale 1ns/1ps
`default_nettype none
module nsr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= INIT;
            dout <= INIT;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : nsr_sync
`default_nettype wire

/* hw/nsr_host.sv */
// Purpose: host controller driving an 8K x 8 nonvolatile static memory
// Assumes: 250 MHz clock, pins sampled through two flops
// Notes: one command at a time; sequences run without interruption
//
// How it works
// - to block stores the host drives store/busy high hard enough.
// - six reads at the store addresses start a software store.
// - the same five reads then 0x0F0E start a software recall.
// - write enable stays high through all six sequence cycles.
`include "nsr_map.svh"
`timescale 1ns/1ps
`default_nettype none
module nsr_host #(
    parameter int SB_LOW_CYC = `NSR_SB_LOW_CYC,
    parameter int NV_CYC = `NSR_NV_CYC
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire nsr_pkg::nsr_cmd_type cmd,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    // status
    input wire logic store_inhibit,
    output logic busy,
    output logic dirty,
    // memory pins
    output nsr_pkg::nsr_pins_type pins,
    input wire logic [7:0] dq_i,
    input wire logic hw_store_busy_n_i
);
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_SETUP = 6'h02,
        ST_HOLD = 6'h04,
        ST_GAP = 6'h08,
        ST_SB_PULSE = 6'h10,
        ST_NVWAIT = 6'h20
    } nsr_state_type;

    nsr_state_type state_q, state_d;
    nsr_pkg::nsr_cmd_type cmd_q;
    nsr_pkg::nsr_pins_type pins_d;
    logic [31:0] cnt_q, cnt_d;
    logic [2:0] step_q;
    logic [7:0] dq_s;
    logic sb_s;
    logic seq_op;
    logic [12:0] cur_addr;
    logic take;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    nsr_sync #(.WIDTH(8), .INIT(8'h00)) u_dq_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(dq_i),
        .dout(dq_s)
    );

    nsr_sync #(.WIDTH(1), .INIT(1'h1)) u_sb_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .din(hw_store_busy_n_i),
        .dout(sb_s)
    );

    ////////////////////////////////////////////////////////////////////
    // command accept
    assign seq_op = (cmd_q.op == nsr_pkg::NSR_OP_SW_STORE) ||
                    (cmd_q.op == nsr_pkg::NSR_OP_SW_RECALL);
    // no access while device is busy; only a hardware store is refused while store_inhibit is set
    assign cmd_ready = (state_q == ST_IDLE) && sb_s &&
                       !(store_inhibit &&
                         cmd.op == nsr_pkg::NSR_OP_HW_STORE);
    assign take = cmd_valid && cmd_ready;
    assign busy = (state_q != ST_IDLE) || !sb_s;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cmd_q <= '0;
        end else if (take) begin
            cmd_q <= cmd;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequence address table
    always_comb begin
        cur_addr = cmd_q.addr;
        if (seq_op) begin
            case (step_q)
                3'h0: cur_addr = `NSR_SEQ_A0;
                3'h1: cur_addr = `NSR_SEQ_A1;
                3'h2: cur_addr = `NSR_SEQ_A2;
                3'h3: cur_addr = `NSR_SEQ_A3;
                3'h4: cur_addr = `NSR_SEQ_A4;
                default: begin
                    if (cmd_q.op == nsr_pkg::NSR_OP_SW_STORE) begin
                        cur_addr = `NSR_SEQ_STORE;
                    end else begin
                        cur_addr = `NSR_SEQ_RECALL;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state machine
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    if (cmd.op == nsr_pkg::NSR_OP_HW_STORE) begin
                        state_d = ST_SB_PULSE;
                        cnt_d = 32'(`NSR_SB_PULSE_CYC - 1);
                    end else begin
                        state_d = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                state_d = ST_HOLD;
                cnt_d = 32'(`NSR_ACCESS_CYC - 1);
            end
            ST_HOLD: begin
                if (cnt_q == 32'h0000_0000) begin
                    state_d = ST_GAP;
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
            end
            ST_GAP: begin
                // steps follow directly, nothing may intervene
                if (seq_op && step_q != `NSR_SEQ_LAST) begin
                    state_d = ST_SETUP;
                end else if (seq_op) begin
                    state_d = ST_NVWAIT;
                    cnt_d = 32'(NV_CYC);
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_SB_PULSE: begin
                if (cnt_q == 32'h0000_0000) begin
                    state_d = ST_NVWAIT;
                    cnt_d = 32'(SB_LOW_CYC);
                end else begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end
            end
            ST_NVWAIT: begin
                if (cnt_q != 32'h0000_0000) begin
                    cnt_d = cnt_q - 32'h0000_0001;
                end else if (sb_s) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sequence step
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            step_q <= 3'h0;
        end else if (take) begin
            step_q <= 3'h0;
        end else if (state_q == ST_GAP && seq_op &&
                     step_q != `NSR_SEQ_LAST) begin
            step_q <= step_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data and response
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rsp_rdata <= 8'h00;
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (state_d == ST_IDLE) && (state_q != ST_IDLE);
            if (state_q == ST_HOLD && cnt_q == 32'h0000_0000 &&
                cmd_q.op == nsr_pkg::NSR_OP_READ) begin
                rsp_rdata <= dq_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // written-since-nv tracking
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            dirty <= 1'b0;
        end else if (state_q == ST_GAP &&
                     cmd_q.op == nsr_pkg::NSR_OP_WRITE) begin
            dirty <= 1'b1;
        end else if (state_q == ST_NVWAIT && state_d == ST_IDLE) begin
            dirty <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drive
    always_comb begin
        pins_d.ce_n = 1'b1;
        pins_d.we_n = 1'b1;
        pins_d.oe_n = 1'b1;
        pins_d.addr = cur_addr;
        pins_d.dq_o = cmd_q.wdata;
        pins_d.dq_oe = 1'b0;
        pins_d.sb_o = 1'b1;
        pins_d.sb_oe = 1'b0;
        if (store_inhibit) begin
            pins_d.sb_oe = 1'b1;
        end
        case (state_q)
            ST_SETUP, ST_HOLD: begin
                pins_d.ce_n = 1'b0;
                if (cmd_q.op == nsr_pkg::NSR_OP_WRITE) begin
                    pins_d.dq_oe = 1'b1;
                    pins_d.we_n = (state_q == ST_SETUP);
                end else begin
                    // gate only steers data, last step left ungated
                    pins_d.oe_n = seq_op &&
                                  step_q == `NSR_SEQ_LAST;
                end
            end
            ST_GAP: begin
                pins_d.dq_oe = (cmd_q.op == nsr_pkg::NSR_OP_WRITE);
            end
            ST_SB_PULSE: begin
                pins_d.sb_o = 1'b0;
                pins_d.sb_oe = 1'b1;
            end
            default: begin
                pins_d.ce_n = 1'b1;
            end
        endcase
        if (seq_op) begin
            pins_d.we_n = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 13'h0000,
                      dq_o: 8'h00, dq_oe: 1'b0, sb_o: 1'b1,
                      sb_oe: 1'b0};
        end else begin
            pins <= pins_d;
        end
    end
endmodule : nsr_host
`default_nettype wire

/* testbench/nsr_host_checker.sv */
// Purpose: port assertions for nsr host
// Assumes: one clock, synchronous reset
// Notes: bound to nsr_host
`timescale 1ns/1ps
`default_nettype none
module nsr_host_checker #(
    parameter int SB_LOW_CYC = 20,
    parameter int NV_CYC = 50
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // command port
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire nsr_pkg::nsr_cmd_type cmd,
    input wire logic rsp_valid,
    // memory side
    input wire logic store_inhibit,
    input wire nsr_pkg::nsr_pins_type pins,
    input wire logic hw_store_busy_n_i
);
    localparam logic [12:0] SEQ [6] = '{13'h0000, 13'h1555, 13'h0AAA,
        13'h1FFF, 13'h10F0, 13'h0F0F};
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic take, seq_q;
    logic [2:0] st_q;
    logic [12:0] exp_a;
    nsr_pkg::nsr_cmd_type cmd_q;
    ////////////////////////////////////////
    assign take = cmd_valid && cmd_ready;
    // op bit 0 tells recall from store
    assign exp_a = (st_q == 3'h5 && cmd_q.op[0]) ? 13'h0F0E : SEQ[st_q];
    always_ff @(posedge clock) begin
        if (take) cmd_q <= cmd;
    end
    always_ff @(posedge clock) begin
        if (sys_rst || rsp_valid) seq_q <= 1'b0;
        else if (take) seq_q <= cmd.op inside {nsr_pkg::NSR_OP_SW_STORE,
            nsr_pkg::NSR_OP_SW_RECALL};
    end
    always_ff @(posedge clock) begin
        if (sys_rst || take) st_q <= 3'h0;
        else if (seq_q && $fell(pins.ce_n)) st_q <= st_q + 3'h1;
    end
    ////////////////////////////////////////
    sequence s_rd;
        !pins.ce_n && pins.we_n && !pins.oe_n && pins.addr == cmd_q.addr;
    endsequence
    a_inhibit_drive: assert property (store_inhibit |=> pins.sb_oe)
        else $error("store line undriven");
    a_inhibit_refuse: assert property (
        store_inhibit && cmd.op == nsr_pkg::NSR_OP_HW_STORE |-> !cmd_ready)
        else $error("store taken while inhibited");
    a_busy_refuse: assert property (
        !hw_store_busy_n_i [*3] |-> !cmd_ready)
        else $error("ready while busy");
    a_seq_order: assert property (
        seq_q && $fell(pins.ce_n) |-> pins.addr == exp_a)
        else $error("sequence address wrong");
    a_seq_we_high: assert property (seq_q |-> pins.we_n)
        else $error("write strobe in sequence");
    a_six_steps: assert property (
        seq_q && rsp_valid |-> st_q == 3'h6)
        else $error("sequence not six accesses");
    a_read_mode: assert property (
        take && cmd.op == nsr_pkg::NSR_OP_READ |-> ##[1:3] s_rd ##1 s_rd [*8])
        else $error("read cycle wrong");
    a_write_mode: assert property (
        take && cmd.op == nsr_pkg::NSR_OP_WRITE |-> ##[2:3] (!pins.ce_n &&
        !pins.we_n && pins.dq_oe && pins.dq_o == cmd_q.wdata))
        else $error("write cycle wrong");
endmodule : nsr_host_checker
bind nsr_host nsr_host_checker #(.SB_LOW_CYC(SB_LOW_CYC), .NV_CYC(NV_CYC))
    chk (.clock, .sys_rst, .cmd_valid, .cmd_ready, .cmd, .rsp_valid,
    .store_inhibit, .pins, .hw_store_busy_n_i);
`default_nettype wire

/* testbench/nsr_dev_model.sv */
// Purpose: behavioural nonvolatile static memory
// Assumes: pins sampled on the host clock
// Notes: store time shortened to STORE_CYC
`timescale 1ns/1ps
`default_nettype none
module nsr_dev_model #(
    parameter int STORE_CYC = 30
) (
    // clock
    input wire logic clock,
    // pins
    input wire nsr_pkg::nsr_pins_type pins,
    output logic [7:0] dq,
    output logic sb_n,
    // counts
    output logic [7:0] stores,
    output logic [7:0] recalls
);
    localparam logic [12:0] SEQ [5] = '{13'h0000, 13'h1555, 13'h0AAA,
        13'h1FFF, 13'h10F0};
    logic [7:0] mem [8192];
    logic [7:0] nv [8192];
    logic [12:0] a_q;
    logic [7:0] d_q;
    logic ce_q = 1'b1, wr_q = 1'b0, dirty_q = 1'b0, hold_q = 1'b0;
    logic alt_q = 1'b0;
    logic host_hi, host_lo, live, rd;
    int busy = 0;
    int step = 0;
    initial begin
        stores = 8'h00;
        recalls = 8'h00;
    end
    ////////////////////////////////////////
    assign host_hi = pins.sb_oe && pins.sb_o;
    assign host_lo = pins.sb_oe && !pins.sb_o;
    assign sb_n = host_hi || !(host_lo || busy > 0);
    assign live = sb_n && !hold_q && busy == 0;
    assign rd = live && !pins.ce_n && pins.we_n && !pins.oe_n;
    assign dq = rd ? mem[pins.addr] : {8{alt_q}};
    always @(posedge clock) begin
        alt_q <= ~alt_q;
        ce_q <= pins.ce_n;
        if (!pins.ce_n) a_q <= pins.addr;
        if (!pins.ce_n && !pins.we_n) wr_q <= 1'b1;
        if (!pins.we_n) d_q <= pins.dq_o;
        if (busy > 0) begin
            busy <= host_hi ? 0 : busy - 1;
            if (busy == 1 && !host_hi) begin
                nv <= mem;
                stores <= stores + 8'h01;
            end
        end
        if (pins.ce_n && !ce_q) begin
            wr_q <= 1'b0;
            if (live && wr_q) begin
                mem[a_q] <= d_q;
                dirty_q <= 1'b1;
                step <= 0;
            end else if (live && step < 5) begin
                step <= (a_q == SEQ[step]) ? step + 1 : int'(a_q == 13'h0);
            end else if (live) begin
                step <= 0;
                if (a_q == 13'h0F0F) busy <= STORE_CYC;
                if (a_q == 13'h0F0E) begin
                    mem <= nv;
                    recalls <= recalls + 8'h01;
                end
            end
        end
        if (host_lo && !hold_q) begin
            hold_q <= 1'b1;
            if (dirty_q) busy <= STORE_CYC;
            dirty_q <= 1'b0;
        end else if (sb_n) begin
            hold_q <= 1'b0;
        end
    end
endmodule : nsr_dev_model
`default_nettype wire

/* testbench/testbench.sv */
// Purpose: self-checking bench for nsr host
// Assumes: short store and nv counts
// Notes: device model answers on the pins
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0, sys_rst = 1'b1, cmd_valid = 1'b0;
    logic store_inhibit = 1'b0;
    nsr_pkg::nsr_cmd_type cmd = '0;
    logic cmd_ready, rsp_valid, dirty, sb_n, busy;
    logic [7:0] rsp_rdata, dq, stores, recalls;
    nsr_pkg::nsr_pins_type pins;
    int mismatches = 0;
    int checked = 0;
    // op, address, write data, read data expected
    logic [31:0] rows [6] = '{{3'h1, 13'h0000, 8'hA5, 8'h00},
        {3'h1, 13'h1FFF, 8'h3C, 8'h00}, {3'h1, 13'h0F0F, 8'h81, 8'h00},
        {3'h0, 13'h0000, 8'h00, 8'hA5}, {3'h0, 13'h1FFF, 8'h00, 8'h3C},
        {3'h0, 13'h0F0F, 8'h00, 8'h81}};
    nsr_host #(.SB_LOW_CYC(20), .NV_CYC(50)) uut (.clock, .sys_rst,
        .cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp_rdata, .store_inhibit,
        .busy, .dirty, .pins, .dq_i(dq), .hw_store_busy_n_i(sb_n));
    nsr_dev_model dev (.clock, .pins, .dq, .sb_n, .stores, .recalls);
    ////////////////////////////////////////
    task automatic finish_test;
        if (mismatches == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic run(input logic [2:0] op, input logic [12:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        cmd_valid = 1'b1;
        cmd = {op, a, d};
        @(negedge clock);
        while (!cmd_ready && n < 9000) begin
            n++;
            @(negedge clock);
        end
        @(posedge clock);
        #1;
        cmd_valid = 1'b0;
        chk({7'h0, busy}, 8'h01);
        while (!rsp_valid && n < 9000) begin
            n++;
            @(negedge clock);
        end
        if (n >= 9000) mismatches++;
    endtask : run
    ////////////////////////////////////////
    initial begin
        forever #2 clock = ~clock;
    end
    initial begin
        #80000;
        mismatches++;
        finish_test;
    end
    initial begin
        repeat (5) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        chk({pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe, 2'h0, busy, dirty},
            8'hE0);
        foreach (rows[i]) begin
            run(rows[i][31:29], rows[i][28:16], rows[i][15:8]);
            if (rows[i][31:29] == 3'h0) begin
                chk(rsp_rdata, rows[i][7:0]);
            end
        end
        chk({7'h0, dirty}, 8'h01);
        @(posedge clock);
        #1;
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        chk({pins.ce_n, pins.we_n, pins.oe_n, pins.dq_oe, 2'h0, busy, dirty},
            8'hE0);
        run(3'h4, 13'h0000, 8'h00);
        chk(stores, 8'h01);
        run(3'h4, 13'h0000, 8'h00);
        chk(stores, 8'h01);
        @(posedge clock);
        #1;
        store_inhibit = 1'b1;
        cmd = {3'h4, 13'h0000, 8'h00};
        repeat (2) @(posedge clock);
        @(negedge clock);
        chk({5'h0, busy, cmd_ready, sb_n}, 8'h01);
        run(3'h1, 13'h0000, 8'h5A);
        run(3'h2, 13'h0000, 8'h00);
        chk(stores, 8'h01);
        chk({7'h0, dirty}, 8'h00);
        @(posedge clock);
        #1;
        store_inhibit = 1'b0;
        run(3'h2, 13'h0000, 8'h00);
        chk(stores, 8'h02);
        run(3'h1, 13'h0000, 8'h11);
        run(3'h3, 13'h0000, 8'h00);
        chk(recalls, 8'h01);
        run(3'h0, 13'h0000, 8'h00);
        chk(rsp_rdata, 8'h5A);
        finish_test;
    end
endmodule : testbench
`default_nettype wire
